// ### clkdist_ctrl_regs.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - chip power-down bit forces loop core, both detectors, every divider and every buffer off.
// - each divider-off bit turns off both divider and buffer of its output.
// - each buffer-off bit turns off only the buffer of its output.
// - loop-core power-down turns off reference path, detector, pump, feedback divider.
// - reference detector power-down bit turns the reference-present detector off.
// - oscillator detector power-down bit turns the oscillator-present detector off.
// - ten-bit reference divider modulus; zero and one both divide by one.
// - route bit sends reference divider to output 4, bypassing delay and sync.
// - writing the soft-reset bit returns every register to its default.
// - reference divider reset held until host writes the bit back to zero or a soft reset.
// - feedback divider reset held until host writes the bit back to zero or a soft reset.
// - three-bit revision code is read-only; writes ignored.
// - five-bit part code is read-only; writes ignored.
// - first status pin gates the six flags with mask one, default 0x04.
// - second status pin gates the six flags with mask two, default 0x3b.
// - alignment mode: 00 control, 01 standalone, 10 and 11 follow.
// - an output reacts to the sync pin only when its enable bit is set.
// - sync enables default to one for outputs 0-3, zero for output 4.
// - pump-high flag reads one only while its check is enabled.
// - pump-low flag reads one only while its check is enabled.
// - unlocked flag reads one whenever the loop is out of lock.
// - locked flag reads one while locked and lock detection enabled.
// - flags for missing reference and missing oscillator inputs.
// - each status pin high whenever any unmasked flag is asserted.
module clkdist_ctrl_regs
	import clkdist_regs_pkg::*;
#(
	parameter logic [2:0] REVISION_CODE = 3'h2,  // arbitrary value
	parameter logic [4:0] PART_CODE     = 5'h1a  // arbitrary value
) (
	input  wire logic                   i_mclk,
	input  wire logic                   i_srst,
	input  wire reg_req_type            i_req,
	input  wire logic                   i_pump_above_high,
	input  wire logic                   i_pump_below_low,
	input  wire logic                   i_pump_high_check_enable,
	input  wire logic                   i_pump_low_check_enable,
	input  wire logic                   i_loop_locked,
	input  wire logic                   i_ref_absent,
	input  wire logic                   i_osc_absent,
	input  wire logic                   i_sync_pin,
	output var  logic [7:0]             o_rd_data,
	output var  logic                   o_rd_valid,
	output var  power_ctrl_type         o_power,
	output var  logic [RDIV_WIDTH-1:0]  o_ref_div_modulus,
	output var  logic                   o_ref_div_reset,
	output var  logic                   o_fb_div_reset,
	output var  logic                   o_route_ref_divider_to_out4,
	output var  align_mode_type         o_alignment_mode,
	output var  logic [NUM_OUTPUTS-1:0] o_align_respond,
	output var  logic [NUM_OUTPUTS-1:0] o_align_request,
	output var  logic                   o_status_pin_one,
	output var  logic                   o_status_pin_two
);

	logic [5:0]             pin1_mask_reg;
	logic [5:0]             pin2_mask_reg;
	logic [7:0]             power_ctrl_reg;
	logic [7:0]             out_pd_reg;
	logic [7:0]             rdiv_high_reg;
	logic [7:0]             rdiv_low_reg;
	logic [7:0]             fbdiv_high_reg;
	logic [7:0]             sync_mode_reg;
	logic [7:0]             out_sync_reg [NUM_OUTPUTS];
	logic [7:0]             out4_route_reg;
	logic [NUM_FLAGS-1:0]   flags;
	logic [NUM_OUTPUTS-1:0] align_en;
	logic [NUM_OUTPUTS-1:0] div_off_bits;
	logic [NUM_OUTPUTS-1:0] buf_off_bits;
	logic [RDIV_WIDTH-1:0]  rdiv_value;
	logic [7:0]             rd_next;
	logic                   soft_reset;
	logic                   wr;

	assign wr = i_req.wr_en;
	// the reset bit never gets stored, so it reads back as zero
	assign soft_reset = wr && (i_req.addr == OFF_POWER_CTRL) && i_req.wr_data[BIT_SOFT_RESET];

	// live status flags, qualified by their enables
	always_comb begin
		flags = '0;
		flags[FLAG_PUMP_LOW]    = i_pump_below_low & i_pump_low_check_enable;
		flags[FLAG_PUMP_HIGH]   = i_pump_above_high & i_pump_high_check_enable;
		flags[FLAG_LOCKED]      = i_loop_locked & power_ctrl_reg[BIT_LOCK_DET_EN];
		flags[FLAG_UNLOCKED]    = ~i_loop_locked;
		// a detector powered down by its own bit tells nothing, so its flag stays low
		flags[FLAG_REF_MISSING] = i_ref_absent & ~power_ctrl_reg[BIT_REF_DET_PD];
		flags[FLAG_OSC_MISSING] = i_osc_absent & ~power_ctrl_reg[BIT_OSC_DET_PD];
	end

	// mask registers
	always_ff @(posedge i_mclk) begin
		if (i_srst || soft_reset) begin
			pin1_mask_reg <= RST_PIN1_MASK;
			pin2_mask_reg <= RST_PIN2_MASK;
		end else if (wr) begin
			if (i_req.addr == OFF_PIN1_MASK) begin
				pin1_mask_reg <= i_req.wr_data[5:0];
			end
			if (i_req.addr == OFF_PIN2_MASK) begin
				pin2_mask_reg <= i_req.wr_data[5:0];
			end
		end
	end

	// power and output power-down registers
	always_ff @(posedge i_mclk) begin
		if (i_srst || soft_reset) begin
			power_ctrl_reg <= RST_POWER_CTRL;
			out_pd_reg     <= RST_OUT_PD;
		end else if (wr) begin
			if (i_req.addr == OFF_POWER_CTRL) begin
				power_ctrl_reg <= i_req.wr_data & ~(8'h01 << BIT_SOFT_RESET);
			end
			if (i_req.addr == OFF_OUT_PD) begin
				out_pd_reg <= i_req.wr_data;
			end
		end
	end

	// divider setting registers; reset bits stay until software clears them
	always_ff @(posedge i_mclk) begin
		if (i_srst || soft_reset) begin
			rdiv_high_reg  <= RST_RDIV_HIGH;
			rdiv_low_reg   <= RST_RDIV_LOW;
			fbdiv_high_reg <= RST_FBDIV_HIGH;
		end else if (wr) begin
			if (i_req.addr == OFF_RDIV_HIGH) begin
				rdiv_high_reg <= i_req.wr_data;
			end
			if (i_req.addr == OFF_RDIV_LOW) begin
				rdiv_low_reg <= i_req.wr_data;
			end
			if (i_req.addr == OFF_FBDIV_HIGH) begin
				fbdiv_high_reg <= i_req.wr_data;
			end
		end
	end

	// sync mode register
	always_ff @(posedge i_mclk) begin
		if (i_srst || soft_reset) begin
			sync_mode_reg <= RST_SYNC_MODE;
		end else if (wr) begin
			if (i_req.addr == OFF_SYNC_MODE) begin
				sync_mode_reg <= i_req.wr_data;
			end
		end
	end

	// output 4 divider and route register
	always_ff @(posedge i_mclk) begin
		if (i_srst || soft_reset) begin
			out4_route_reg <= RST_OUT4_ROUTE;
		end else if (wr) begin
			if (i_req.addr == OFF_OUT4_ROUTE) begin
				out4_route_reg <= i_req.wr_data;
			end
		end
	end

	// per-output sync configuration registers
	always_ff @(posedge i_mclk) begin
		if (i_srst || soft_reset) begin
			for (int i = 0; i < NUM_OUTPUTS-1; i++) begin
				out_sync_reg[i] <= RST_DIFF_SYNC;
			end
			out_sync_reg[NUM_OUTPUTS-1] <= RST_OUT4_SYNC;
		end else if (wr) begin
			if (i_req.addr == OFF_OUT0_SYNC) begin
				out_sync_reg[0] <= i_req.wr_data;
			end
			if (i_req.addr == OFF_OUT1_SYNC) begin
				out_sync_reg[1] <= i_req.wr_data;
			end
			if (i_req.addr == OFF_OUT2_SYNC) begin
				out_sync_reg[2] <= i_req.wr_data;
			end
			if (i_req.addr == OFF_OUT3_SYNC) begin
				out_sync_reg[3] <= i_req.wr_data;
			end
			if (i_req.addr == OFF_OUT4_SYNC) begin
				out_sync_reg[4] <= i_req.wr_data;
			end
		end
	end

	// read mux; identity is constant so writes there fall on nothing
	always_comb begin
		rd_next = 8'h00;
		unique case (i_req.addr)
			OFF_STATUS:     rd_next = {2'b00, flags};
			OFF_PIN1_MASK:  rd_next = {2'b00, pin1_mask_reg};
			OFF_PIN2_MASK:  rd_next = {2'b00, pin2_mask_reg};
			OFF_POWER_CTRL: rd_next = power_ctrl_reg;
			OFF_OUT_PD:     rd_next = out_pd_reg;
			OFF_RDIV_HIGH:  rd_next = rdiv_high_reg;
			OFF_RDIV_LOW:   rd_next = rdiv_low_reg;
			OFF_FBDIV_HIGH: rd_next = fbdiv_high_reg;
			OFF_SYNC_MODE:  rd_next = sync_mode_reg;
			OFF_OUT0_SYNC:  rd_next = out_sync_reg[0];
			OFF_OUT1_SYNC:  rd_next = out_sync_reg[1];
			OFF_OUT2_SYNC:  rd_next = out_sync_reg[2];
			OFF_OUT3_SYNC:  rd_next = out_sync_reg[3];
			OFF_OUT4_SYNC:  rd_next = out_sync_reg[4];
			OFF_OUT4_ROUTE: rd_next = out4_route_reg;
			OFF_IDENTITY:   rd_next = {REVISION_CODE, PART_CODE};
			default:        rd_next = 8'h00;
		endcase
	end

	// read strobe: one pulse per accepted read
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_req.rd_en;
		end
	end

	// read data one cycle after the request; held so a slow host can still pick it up
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_rd_data <= 8'h00;
		end else if (i_req.rd_en) begin
			o_rd_data <= rd_next;
		end
	end

	// gather the per-output power-down bits into vectors
	always_comb begin
		div_off_bits = {out_pd_reg[6], out_pd_reg[4], out_pd_reg[2], out_pd_reg[0],
			power_ctrl_reg[BIT_OUT0_DIV_OFF]};
		buf_off_bits = {out_pd_reg[7], out_pd_reg[5], out_pd_reg[3], out_pd_reg[1],
			power_ctrl_reg[BIT_OUT0_BUF_OFF]};
	end

	// power-down outputs; chip power-down overrides every section
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_power <= '0;
		end else begin
			o_power.chip_power_down       <= power_ctrl_reg[BIT_CHIP_PD];
			o_power.loop_core_power_down  <= power_ctrl_reg[BIT_CHIP_PD] | power_ctrl_reg[BIT_LOOP_PD];
			o_power.ref_detect_power_down <= power_ctrl_reg[BIT_CHIP_PD] | power_ctrl_reg[BIT_REF_DET_PD];
			o_power.osc_detect_power_down <= power_ctrl_reg[BIT_CHIP_PD] | power_ctrl_reg[BIT_OSC_DET_PD];
			o_power.divider_off <= {NUM_OUTPUTS{power_ctrl_reg[BIT_CHIP_PD]}} | div_off_bits;
			// a divider-off also kills the buffer; buffer-off leaves the divider alone
			o_power.buffer_off  <= {NUM_OUTPUTS{power_ctrl_reg[BIT_CHIP_PD]}} | div_off_bits | buf_off_bits;
		end
	end

	assign rdiv_value = {rdiv_high_reg[1:0], rdiv_low_reg};

	// divider modulus
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_ref_div_modulus <= RDIV_WIDTH'(1);
		end else begin
			// zero would mean nothing to a counter, so it is treated as one
			o_ref_div_modulus <= (rdiv_value == '0) ? RDIV_WIDTH'(1) : rdiv_value;
		end
	end

	// divider resets; held as long as the host leaves the bit set
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_ref_div_reset <= 1'b0;
			o_fb_div_reset  <= 1'b0;
		end else begin
			o_ref_div_reset <= rdiv_high_reg[BIT_RDIV_RESET];
			o_fb_div_reset  <= fbdiv_high_reg[BIT_FBDIV_RESET];
		end
	end

	// sync enables; a routed output 4 bypasses alignment entirely
	always_comb begin
		for (int i = 0; i < NUM_OUTPUTS; i++) begin
			align_en[i] = out_sync_reg[i][BIT_ALIGN_EN];
		end
		if (out4_route_reg[BIT_ROUTE_RDIV]) begin
			align_en[NUM_OUTPUTS-1] = 1'b0;
		end
	end

	// mode decode; both upper codes mean follow
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_alignment_mode <= ALIGN_STANDALONE;
		end else begin
			unique case (sync_mode_reg[MODE_MSB:MODE_LSB])
				2'b00: o_alignment_mode   <= ALIGN_CONTROL;
				2'b01: o_alignment_mode   <= ALIGN_STANDALONE;
				default: o_alignment_mode <= ALIGN_FOLLOW;
			endcase
		end
	end

	// output 4 route select
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_route_ref_divider_to_out4 <= 1'b1;
		end else begin
			o_route_ref_divider_to_out4 <= out4_route_reg[BIT_ROUTE_RDIV];
		end
	end

	// sync fan-out; the request lags the pin by one cycle, the price of registered outputs
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_align_respond <= '0;
			o_align_request <= '0;
		end else begin
			o_align_respond <= align_en;
			o_align_request <= align_en & {NUM_OUTPUTS{i_sync_pin}};
		end
	end

	// status pins
	status_pin_gate #(
		.WIDTH (NUM_FLAGS)
	) u_pin_one (
		.i_mclk  (i_mclk),
		.i_srst  (i_srst),
		.i_flags (flags),
		.i_mask  (pin1_mask_reg),
		.o_pin   (o_status_pin_one)
	);

	status_pin_gate #(
		.WIDTH (NUM_FLAGS)
	) u_pin_two (
		.i_mclk  (i_mclk),
		.i_srst  (i_srst),
		.i_flags (flags),
		.i_mask  (pin2_mask_reg),
		.o_pin   (o_status_pin_two)
	);

endmodule

`default_nettype wire

// ### clkdist_ctrl_regs_chk.sv
`timescale 1ns/10ps
`default_nettype none

module clkdist_ctrl_regs_chk
	import clkdist_regs_pkg::*;
#(
	parameter logic [2:0] REVISION_CODE = 3'h0,  // arbitrary value
	parameter logic [4:0] PART_CODE     = 5'h00  // arbitrary value
) (
	input wire logic                   i_mclk,
	input wire logic                   i_srst,
	input wire reg_req_type            i_req,
	input wire logic                   i_pump_above_high,
	input wire logic                   i_pump_below_low,
	input wire logic                   i_pump_high_check_enable,
	input wire logic                   i_pump_low_check_enable,
	input wire logic                   i_loop_locked,
	input wire logic                   i_sync_pin,
	input wire logic [7:0]             o_rd_data,
	input wire logic                   o_rd_valid,
	input wire power_ctrl_type         o_power,
	input wire logic [RDIV_WIDTH-1:0]  o_ref_div_modulus,
	input wire logic                   o_route_ref_divider_to_out4,
	input wire align_mode_type         o_alignment_mode,
	input wire logic [NUM_OUTPUTS-1:0] o_align_respond,
	input wire logic [NUM_OUTPUTS-1:0] o_align_request
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_srst);

	// read port answers exactly one cycle after the request
	a_read_answer: assert property (i_req.rd_en |=> o_rd_valid)
		else $error("read not answered");
	a_valid_cause: assert property (o_rd_valid |-> $past(i_req.rd_en))
		else $error("read valid without a read");
	a_identity_read: assert property (i_req.rd_en && i_req.addr == OFF_IDENTITY |=>
		o_rd_data == {REVISION_CODE, PART_CODE}) else $error("identity byte wrong");
	// live flags: reading samples the inputs of the read edge
	a_status_read: assert property (i_req.rd_en && i_req.addr == OFF_STATUS |=>
		o_rd_data[3] == !$past(i_loop_locked)
		&& o_rd_data[1] == ($past(i_pump_above_high) && $past(i_pump_high_check_enable))
		&& o_rd_data[0] == ($past(i_pump_below_low) && $past(i_pump_low_check_enable)))
		else $error("status flags wrong");
	a_align_gate: assert property (o_align_request == (o_align_respond & {NUM_OUTPUTS{$past(i_sync_pin)}}))
		else $error("align request not gated by enable");
	a_chip_all_off: assert property (o_power.chip_power_down |->
		&{o_power.loop_core_power_down, o_power.ref_detect_power_down, o_power.osc_detect_power_down,
		o_power.divider_off, o_power.buffer_off}) else $error("chip power-down leaves a block on");
	a_div_with_buf: assert property ((o_power.divider_off & ~o_power.buffer_off) == '0)
		else $error("divider off without buffer off");
	a_modulus_nonzero: assert property (o_ref_div_modulus != '0)
		else $error("reference modulus zero");
	a_route_no_sync: assert property (o_route_ref_divider_to_out4 |-> !o_align_respond[4])
		else $error("routed output still aligns");
	a_mode_legal: assert property (i_req.wr_en && i_req.addr == OFF_SYNC_MODE |-> ##2
		o_alignment_mode == ($past(i_req.wr_data[MODE_MSB], 2) ? ALIGN_FOLLOW
		: ($past(i_req.wr_data[MODE_LSB], 2) ? ALIGN_STANDALONE : ALIGN_CONTROL)))
		else $error("alignment mode decode wrong");
	// soft reset: registers at the write edge, outputs one edge later
	a_soft_reset: assert property (i_req.wr_en && i_req.addr == OFF_POWER_CTRL && i_req.wr_data[BIT_SOFT_RESET]
		|-> ##2 (o_align_respond == 5'h0f && o_ref_div_modulus == 10'h001 && o_power == '0
		&& o_alignment_mode == ALIGN_STANDALONE)) else $error("soft reset incomplete");

	c_soft_reset: cover property (i_req.wr_en && i_req.addr == OFF_POWER_CTRL && i_req.wr_data[BIT_SOFT_RESET]);
	c_chip_off: cover property (o_power.chip_power_down);
	c_align_req: cover property (|o_align_request);
endmodule

bind clkdist_ctrl_regs clkdist_ctrl_regs_chk #(.REVISION_CODE(REVISION_CODE), .PART_CODE(PART_CODE)) u_chk (
	.i_mclk(i_mclk), .i_srst(i_srst), .i_req(i_req), .i_pump_above_high(i_pump_above_high),
	.i_pump_below_low(i_pump_below_low), .i_pump_high_check_enable(i_pump_high_check_enable),
	.i_pump_low_check_enable(i_pump_low_check_enable), .i_loop_locked(i_loop_locked), .i_sync_pin(i_sync_pin),
	.o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_power(o_power), .o_ref_div_modulus(o_ref_div_modulus),
	.o_route_ref_divider_to_out4(o_route_ref_divider_to_out4), .o_alignment_mode(o_alignment_mode),
	.o_align_respond(o_align_respond), .o_align_request(o_align_request));

`default_nettype wire

// ### clkdist_regs_pkg.sv
package clkdist_regs_pkg;

	// register offsets
	localparam logic [6:0] OFF_STATUS     = 7'h00;
	localparam logic [6:0] OFF_PIN1_MASK  = 7'h01;
	localparam logic [6:0] OFF_PIN2_MASK  = 7'h02;
	localparam logic [6:0] OFF_POWER_CTRL = 7'h03;
	localparam logic [6:0] OFF_OUT_PD     = 7'h04;
	localparam logic [6:0] OFF_RDIV_HIGH  = 7'h07;
	localparam logic [6:0] OFF_RDIV_LOW   = 7'h08;
	localparam logic [6:0] OFF_FBDIV_HIGH = 7'h09;
	localparam logic [6:0] OFF_SYNC_MODE  = 7'h0b;
	localparam logic [6:0] OFF_OUT0_SYNC  = 7'h0c;
	localparam logic [6:0] OFF_OUT1_SYNC  = 7'h0e;
	localparam logic [6:0] OFF_OUT2_SYNC  = 7'h10;
	localparam logic [6:0] OFF_OUT3_SYNC  = 7'h12;
	localparam logic [6:0] OFF_OUT4_SYNC  = 7'h14;
	localparam logic [6:0] OFF_OUT4_ROUTE = 7'h15;
	localparam logic [6:0] OFF_IDENTITY   = 7'h16;

	// reset values
	localparam logic [5:0] RST_PIN1_MASK  = 6'h04;
	localparam logic [5:0] RST_PIN2_MASK  = 6'h3b;
	localparam logic [7:0] RST_POWER_CTRL = 8'h08;
	localparam logic [7:0] RST_OUT_PD     = 8'h00;
	localparam logic [7:0] RST_RDIV_HIGH  = 8'h00;
	localparam logic [7:0] RST_RDIV_LOW   = 8'h01;
	localparam logic [7:0] RST_FBDIV_HIGH = 8'h00;
	localparam logic [7:0] RST_SYNC_MODE  = 8'h40;
	localparam logic [7:0] RST_DIFF_SYNC  = 8'h80;
	localparam logic [7:0] RST_OUT4_SYNC  = 8'h00;
	localparam logic [7:0] RST_OUT4_ROUTE = 8'ha0;

	// field positions
	localparam int BIT_CHIP_PD      = 7;
	localparam int BIT_LOOP_PD      = 6;
	localparam int BIT_OSC_DET_PD   = 5;
	localparam int BIT_REF_DET_PD   = 4;
	localparam int BIT_LOCK_DET_EN  = 3;
	localparam int BIT_SOFT_RESET   = 2;
	localparam int BIT_OUT0_BUF_OFF = 1;
	localparam int BIT_OUT0_DIV_OFF = 0;
	localparam int BIT_RDIV_RESET   = 3;
	localparam int BIT_FBDIV_RESET  = 4;
	localparam int BIT_ROUTE_RDIV   = 7;
	localparam int BIT_ALIGN_EN     = 7;
	localparam int MODE_MSB         = 7;
	localparam int MODE_LSB         = 6;
	localparam int FLAG_PUMP_LOW    = 0;
	localparam int FLAG_PUMP_HIGH   = 1;
	localparam int FLAG_LOCKED      = 2;
	localparam int FLAG_UNLOCKED    = 3;
	localparam int FLAG_REF_MISSING = 4;
	localparam int FLAG_OSC_MISSING = 5;

	localparam int NUM_OUTPUTS = 5;
	localparam int NUM_FLAGS   = 6;
	localparam int RDIV_WIDTH  = 10;

	typedef enum logic [1:0] {
		ALIGN_CONTROL,
		ALIGN_STANDALONE,
		ALIGN_FOLLOW
	} align_mode_type;

	// power-down controls as they leave the block
	typedef struct packed {
		logic                   chip_power_down;
		logic                   loop_core_power_down;
		logic                   ref_detect_power_down;
		logic                   osc_detect_power_down;
		logic [NUM_OUTPUTS-1:0] divider_off;
		logic [NUM_OUTPUTS-1:0] buffer_off;
	} power_ctrl_type;

	// register access request
	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [6:0] addr;
		logic [7:0] wr_data;
	} reg_req_type;

endpackage

// ### host_model.sv
`timescale 1ns/10ps
`default_nettype none

// host side of the register port; one request per call, serial framing abstracted away
module host_model
	import clkdist_regs_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rd_valid,
	input  wire logic [7:0]  i_rd_data,
	output var  reg_req_type o_req
);
	initial o_req = '0;

	// an edge passes between calls, so the request is never assigned twice at once
	// divider resets are left by writing the bit back to zero or by a soft reset
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		o_req <= '{1'b1, 1'b0, a, d};
		@(posedge i_mclk);
		o_req <= '0;
	endtask

	// answer awaited under a bound; ok low means it never came
	task automatic rd(input logic [6:0] a, output logic [7:0] d, output bit ok);
		int n;
		@(posedge i_mclk);
		o_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge i_mclk);
		o_req <= '0;
		for (n = 0; n < 4; n++) begin
			#1;
			if (i_rd_valid === 1'b1)
				break;
			@(posedge i_mclk);
		end
		ok = (n < 4);
		d = i_rd_data;
	endtask
endmodule

`default_nettype wire

// ### status_pin_gate.sv
`timescale 1ns/10ps
`default_nettype none

module status_pin_gate #(
	parameter int WIDTH = 6
) (
	input  wire logic             i_mclk,
	input  wire logic             i_srst,
	input  wire logic [WIDTH-1:0] i_flags,
	input  wire logic [WIDTH-1:0] i_mask,
	output var  logic             o_pin
);

	// pin high when any unmasked flag is up; registered so the pin never glitches
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_pin <= 1'b0;
		end else begin
			o_pin <= |(i_flags & i_mask);
		end
	end

endmodule

`default_nettype wire

// ### testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import clkdist_regs_pkg::*;

	logic           i_mclk, i_srst, sync, rval, rrst, frst, route, p1, p2;
	logic [6:0]     cnd;  // osc, ref, high_en, high, low_en, low, locked
	logic [7:0]     rdat;
	logic [9:0]     modl;
	logic [4:0]     resp, areq;
	reg_req_type    req;
	power_ctrl_type pwr;
	align_mode_type mode;
	int             fails = 0;
	int             total_checks = 0;

	// identity values are arbitrary
	clkdist_ctrl_regs #(.REVISION_CODE(3'h6), .PART_CODE(5'h0c)) u_dut (
		.i_mclk(i_mclk), .i_srst(i_srst), .i_req(req), .i_pump_above_high(cnd[3]), .i_pump_below_low(cnd[1]),
		.i_pump_high_check_enable(cnd[4]), .i_pump_low_check_enable(cnd[2]), .i_loop_locked(cnd[0]),
		.i_ref_absent(cnd[5]), .i_osc_absent(cnd[6]), .i_sync_pin(sync), .o_rd_data(rdat), .o_rd_valid(rval),
		.o_power(pwr), .o_ref_div_modulus(modl), .o_ref_div_reset(rrst), .o_fb_div_reset(frst),
		.o_route_ref_divider_to_out4(route), .o_alignment_mode(mode), .o_align_respond(resp),
		.o_align_request(areq), .o_status_pin_one(p1), .o_status_pin_two(p2));
	host_model u_host (.i_mclk(i_mclk), .i_rd_valid(rval), .i_rd_data(rdat), .o_req(req));

	task automatic check(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic print_verdict();
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// sample just after an edge, once its updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask

	// a missing answer ends the run
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		bit ok;
		u_host.rd(a, d, ok);
		if (!ok) begin
			fails++;
			print_verdict();
		end
	endtask

	// every writable byte at its default, unmapped 0x05 reads zero
	task automatic t_defaults();
		logic [6:0] a [15] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h07, 7'h08, 7'h09, 7'h0b, 7'h0c, 7'h0e, 7'h10,
			7'h12, 7'h14, 7'h15, 7'h05};
		logic [7:0] e [15] = '{8'h04, 8'h3b, 8'h08, 8'h00, 8'h00, 8'h01, 8'h00, 8'h40, 8'h80, 8'h80, 8'h80,
			8'h80, 8'h00, 8'ha0, 8'h00};
		logic [7:0] d;
		check({modl, resp, route}, {10'h001, 5'h0f, 1'b1});
		for (int i = 0; i < 15; i++) begin
			rd(a[i], d);
			check(d, e[i]);
		end
	endtask

	// read-only identity ignores a write
	task automatic t_identity();
		logic [7:0] d;
		u_host.wr(7'h16, 8'h00);
		rd(7'h16, d);
		check(d, 8'hcc);
	endtask

	// each power-down and output-0 off bit alone, the output bits four at a time, then the whole chip
	task automatic t_power();
		logic [7:0]  c [9] = '{8'h08, 8'h48, 8'h18, 8'h28, 8'h09, 8'h0a, 8'h08, 8'h08, 8'h88};
		logic [7:0]  o [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55, 8'haa, 8'h00};
		logic [13:0] e [9] = '{14'h0000, 14'h1000, 14'h0800, 14'h0400, 14'h0021, 14'h0001, 14'h03de,
			14'h001e, 14'h3fff};
		for (int i = 0; i < 9; i++) begin
			u_host.wr(7'h03, c[i]);
			u_host.wr(7'h04, o[i]);
			tick(1);
			check(pwr, e[i]);
		end
		u_host.wr(7'h03, 8'h08);
	endtask

	// modulus extremes, resets held across unrelated writes
	task automatic t_divider();
		u_host.wr(7'h07, 8'h03);
		u_host.wr(7'h08, 8'hff);
		tick(1);
		check(modl, 10'h3ff);
		u_host.wr(7'h07, 8'h08);
		u_host.wr(7'h08, 8'h00);
		u_host.wr(7'h09, 8'h10);
		tick(3);
		check({rrst, frst, modl}, {2'b11, 10'h001});
		u_host.wr(7'h07, 8'h00);
		u_host.wr(7'h09, 8'h00);
		tick(1);
		check({rrst, frst}, 2'b00);
	endtask

	// flag conditions one at a time; a second read must match the first
	task automatic t_status();
		logic [6:0] v [8] = '{7'h01, 7'h00, 7'h03, 7'h07, 7'h09, 7'h19, 7'h21, 7'h41};
		logic [7:0] f [8] = '{8'h04, 8'h08, 8'h04, 8'h05, 8'h04, 8'h06, 8'h14, 8'h24};
		logic [7:0] d;
		for (int i = 0; i < 8; i++) begin
			@(posedge i_mclk);
			cnd <= v[i];
			rd(7'h00, d);
			check(d, f[i]);
			rd(7'h00, d);
			check({d, p1, p2}, {f[i], |(f[i][5:0] & 6'h04), |(f[i][5:0] & 6'h3b)});
		end
		u_host.wr(7'h01, 8'he0);
		rd(7'h01, d);
		check(d, 8'h20);
		u_host.wr(7'h03, 8'h28);
		tick(1);
		check(p1, 1'b0);
		u_host.wr(7'h03, 8'h08);
		tick(1);
		check(p1, 1'b1);
		u_host.wr(7'h03, 8'h00);
		rd(7'h00, d);
		check(d, 8'h20);
		u_host.wr(7'h03, 8'h08);
	endtask

	// all four mode codes, then enables with the sync pin high
	task automatic t_sync();
		logic [7:0]     m [4] = '{8'h00, 8'h40, 8'h80, 8'hc0};
		align_mode_type e [4] = '{ALIGN_CONTROL, ALIGN_STANDALONE, ALIGN_FOLLOW, ALIGN_FOLLOW};
		for (int i = 0; i < 4; i++) begin
			u_host.wr(7'h0b, m[i]);
			tick(1);
			check(mode, e[i]);
		end
		@(posedge i_mclk);
		sync <= 1'b1;
		u_host.wr(7'h0c, 8'h00);
		tick(1);
		check({resp, areq}, {5'h0e, 5'h0e});
		u_host.wr(7'h15, 8'h20);
		u_host.wr(7'h14, 8'h80);
		tick(1);
		check({resp, areq, route}, {5'h1e, 5'h1e, 1'b0});
		u_host.wr(7'h15, 8'ha0);
		tick(1);
		check({resp[4], route}, 2'b01);
	endtask

	// soft reset restores defaults and clears its own bit
	task automatic t_soft_reset();
		logic [7:0] d;
		u_host.wr(7'h01, 8'h3f);
		u_host.wr(7'h03, 8'h04);
		tick(1);
		check({resp, mode, route}, {5'h0f, ALIGN_STANDALONE, 1'b1});
		rd(7'h01, d);
		check(d, 8'h04);
		rd(7'h03, d);
		check(d, 8'h08);
	endtask

	initial begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end

	initial begin
		i_srst = 1'b1;
		sync = 1'b0;
		cnd = 7'h01;
		repeat (3) @(posedge i_mclk);
		i_srst <= 1'b0;
		tick(1);
		t_defaults();
		t_identity();
		t_power();
		t_divider();
		t_status();
		t_sync();
		t_soft_reset();
		print_verdict();
	end
endmodule

`default_nettype wire
